// ---- tape_host_bus_if.sv ----
// Host-bus side of the streaming tape adapter: decoder, strobes, interrupt.
// Assumes bus and drive pins are asynchronous; AHB-Lite master on mclk_in.
`timescale 1ns/1ns
`include "tape_host_cfg.svh"
module tape_host_bus_if
    import tape_host_pkg::*;
#(
    parameter int CTRL_WIDTH = 4
) (
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    // System bus pins
    input  wire logic [9:0]  sys_addr_in,
    input  wire logic        addr_enable_in,
    input  wire logic        io_read_n_in,
    input  wire logic        io_write_n_in,
    input  wire logic        terminal_count_in,
    input  wire logic        bus_reset_in,
    input  wire logic [3:0]  dma_ack_n_in,
    input  wire logic [3:0]  tape_data_in,
    // Tape drive pins
    input  wire logic        drive_exception_n_in,
    input  wire logic        drive_ack_n_in,
    input  wire logic        drive_ready_n_in,
    input  wire logic        drive_dir_n_in,
    // Decoded port strobes
    output logic             read_status_strobe_n_out,
    output logic             drive_status_read_strobe_n_out,
    output logic             command_request_write_strobe_n_out,
    output logic             read_engine_on_strobe_n_out,
    output logic             control_reg_write_strobe_n_out,
    output logic             irq_ack_strobe_n_out,
    // Board outputs
    output logic [7:0]       tape_data_out,
    output logic             tape_data_oe_out,
    output logic             sys_data_dir_out,
    output logic             sys_data_enable_out,
    output logic [3:0]       irq_out,
    output logic             operation_kill_out,
    output logic             read_mode_out,
    output logic             request_n_out,
    output logic             dma_request_out,
    output logic             drive_drive_n_a_n_out,
    output logic             drive_reset_n_out,
    output logic             master_reset_n_out,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out
);

    generate
        if (CTRL_WIDTH != 4) begin : g_bad_width
            $error("CTRL_WIDTH must be 4");
        end
    endgenerate

    localparam int SYNC_W = 27;

    logic [SYNC_W-1:0]     meta_q;
    logic [SYNC_W-1:0]     sync_q;
    logic [5:0]            port_q;
    logic [5:0]            port_prev_q;
    logic [5:0]            port_rise;
    logic [5:0]            port_fall;
    logic [5:0]            config_q;
    logic [CTRL_WIDTH-1:0] ctrl_q;
    cmd_state_t            cmd_q;
    logic                  irq_q;
    logic                  read_mode_q;
    logic                  kill_q;
    logic                  tc_prev_q;
    logic                  exc_prev_q;
    logic                  dma_req_q;
    logic                  end_of_cmd;
    logic                  exc_event;
    logic                  tc_event;
    logic                  dack_sel_n;
    logic                  master_reset_n;
    logic                  ahb_wr_q;
    logic [7:0]            ahb_addr_q;
    logic                  ahb_take;
    logic [31:0]           hrdata_q;

    // Two-stage synchroniser for all asynchronous pins
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            meta_q <= `SYNC_IDLE;
            sync_q <= `SYNC_IDLE;
        end else begin
            meta_q <= {tape_data_in, dma_ack_n_in, drive_dir_n_in, drive_ready_n_in,
                       drive_ack_n_in, drive_exception_n_in, bus_reset_in,
                       terminal_count_in, io_write_n_in, io_read_n_in,
                       addr_enable_in, sys_addr_in};
            sync_q <= meta_q;
        end
    end

    // Master reset from bus reset; mclk_in is the board master clock
    assign master_reset_n = rst_n_in && !sync_q[`SY_BUS_RESET];
    assign master_reset_n_out = master_reset_n;

    function automatic logic [9:0] base_addr(input logic [1:0] sel);
        case (sel)
            2'd0:    base_addr = `BASE_ADDR_0;
            2'd1:    base_addr = `BASE_ADDR_1;
            2'd2:    base_addr = `BASE_ADDR_2;
            default: base_addr = `BASE_ADDR_3;
        endcase
    endfunction : base_addr

    function automatic logic [5:0] port_decode(input logic [9:0] addr,
                                               input logic [1:0] sel,
                                               input logic       aen,
                                               input logic       rd_n,
                                               input logic       wr_n);
        logic [5:0] p;
        logic [9:0] b;
        logic       hit;
        p   = 6'h00;
        b   = base_addr(sel);
        hit = !aen && (addr[9:2] == b[9:2]);
        if (hit && (rd_n != wr_n)) begin
            case (addr[1:0])
                `OFS_STATUS:  p[rd_n ? `PORT_WR_COMMAND : `PORT_RD_STATUS] = 1'b1;
                `OFS_DRIVE:   p[rd_n ? `PORT_WR_CONTROL : `PORT_RD_DRIVE] = 1'b1;
                `OFS_ENGINE:  p[`PORT_RD_ENGINE] = !rd_n;
                `OFS_IRQ_ACK: p[`PORT_IRQ_ACK] = !wr_n;
                default:      p = 6'h00;
            endcase
        end
        port_decode = p;
    endfunction : port_decode

    // One-hot strobe decode
    always_ff @(posedge mclk_in) begin
        if (!master_reset_n) begin
            port_q      <= 6'h00;
            port_prev_q <= 6'h00;
        end else begin
            port_q      <= port_decode(sync_q[`SY_ADDR_LO +: 10],
                                       config_q[`CFG_BASE_LO +: 2], sync_q[`SY_AEN],
                                       sync_q[`SY_IOR_N], sync_q[`SY_IOW_N]);
            port_prev_q <= port_q;
        end
    end

    assign port_rise = port_q & ~port_prev_q;
    assign port_fall = ~port_q & port_prev_q;

    assign read_status_strobe_n_out           = !port_q[`PORT_RD_STATUS];
    assign drive_status_read_strobe_n_out     = !port_q[`PORT_RD_DRIVE];
    assign command_request_write_strobe_n_out = !port_q[`PORT_WR_COMMAND];
    assign read_engine_on_strobe_n_out        = !port_q[`PORT_RD_ENGINE];
    assign control_reg_write_strobe_n_out     = !port_q[`PORT_WR_CONTROL];
    assign irq_ack_strobe_n_out               = !port_q[`PORT_IRQ_ACK];

    // Data buffer direction and enable
    always_ff @(posedge mclk_in) begin
        if (!master_reset_n) begin
            sys_data_dir_out    <= 1'b0;
            sys_data_enable_out <= 1'b0;
        end else begin
            sys_data_dir_out    <= !sync_q[`SY_IOR_N];
            sys_data_enable_out <= !sync_q[`SY_AEN] && (port_q != 6'h00);
        end
    end

    // Write control register
    always_ff @(posedge mclk_in) begin
        if (!master_reset_n) begin
            ctrl_q <= `CTL_RESET;
        end else if (port_rise[`PORT_WR_CONTROL]) begin
            ctrl_q <= sync_q[`SY_TD_LO +: 4];
        end
    end

    assign drive_drive_n_a_n_out = !ctrl_q[`CTL_DRIVE_N_A];
    assign drive_reset_n_out  = !ctrl_q[`CTL_DRIVE_RESET];

    // Drive status onto the tape-side bus
    always_ff @(posedge mclk_in) begin
        if (!master_reset_n) begin
            tape_data_out    <= 8'h00;
            tape_data_oe_out <= 1'b0;
        end else begin
            tape_data_oe_out <= port_q[`PORT_RD_DRIVE];
            tape_data_out    <= {sync_q[`SY_DIR_N], sync_q[`SY_EXC_N],
                                 sync_q[`SY_RDY_N], sync_q[`SY_ACK_N], ctrl_q};
        end
    end

    // Terminal count and exception edges
    always_ff @(posedge mclk_in) begin
        if (!master_reset_n) begin
            tc_prev_q  <= 1'b0;
            exc_prev_q <= 1'b1;
        end else begin
            tc_prev_q  <= sync_q[`SY_TC];
            exc_prev_q <= sync_q[`SY_EXC_N];
        end
    end

    assign tc_event  = sync_q[`SY_TC] && !tc_prev_q;
    assign exc_event = !sync_q[`SY_EXC_N] && exc_prev_q;

    // Kill pulse on terminal count
    always_ff @(posedge mclk_in) begin
        if (!master_reset_n) begin
            kill_q <= 1'b0;
        end else begin
            kill_q <= tc_event;
        end
    end

    assign operation_kill_out = kill_q;

    // Read operation mode
    always_ff @(posedge mclk_in) begin
        if (!master_reset_n) begin
            read_mode_q <= 1'b0;
        end else if (port_rise[`PORT_RD_ENGINE]) begin
            read_mode_q <= 1'b1;
        end else if (kill_q) begin
            read_mode_q <= 1'b0;
        end
    end

    assign read_mode_out = read_mode_q;

    // Request generator
    always_ff @(posedge mclk_in) begin
        if (!master_reset_n) begin
            cmd_q <= CMD_IDLE;
        end else begin
            case (cmd_q)
                CMD_IDLE: begin
                    if (port_fall[`PORT_WR_COMMAND]) begin
                        cmd_q <= CMD_BUSY;
                    end
                end
                CMD_BUSY: begin
                    if (kill_q) begin
                        cmd_q <= CMD_IDLE;
                    end else if (!sync_q[`SY_RDY_N]) begin
                        cmd_q <= CMD_DONE;
                    end
                end
                CMD_DONE: cmd_q <= CMD_IDLE;
                default:  cmd_q <= CMD_IDLE;
            endcase
        end
    end

    assign end_of_cmd    = (cmd_q == CMD_DONE);
    assign request_n_out = (cmd_q != CMD_BUSY);

    // DMA request, cleared by the selected acknowledge
    assign dack_sel_n = sync_q[`SY_DACK_LO + config_q[`CFG_DACK_LO +: 2]];

    always_ff @(posedge mclk_in) begin
        if (!master_reset_n) begin
            dma_req_q <= 1'b0;
        end else if (!dack_sel_n || kill_q) begin
            dma_req_q <= 1'b0;
        end else if (read_mode_q && !sync_q[`SY_RDY_N]) begin
            dma_req_q <= 1'b1;
        end
    end

    assign dma_request_out = dma_req_q;

    // Interrupt request; a new event wins over acknowledge
    always_ff @(posedge mclk_in) begin
        if (!master_reset_n) begin
            irq_q <= 1'b0;
        end else if (end_of_cmd || exc_event) begin
            irq_q <= 1'b1;
        end else if (port_rise[`PORT_IRQ_ACK]) begin
            irq_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!master_reset_n) begin
            irq_out <= 4'h0;
        end else begin
            irq_out <= {3'b000, irq_q} << config_q[`CFG_IRQ_LO +: 2];
        end
    end

    // AHB-Lite slave, zero wait states
    assign ahb_take      = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ
                           || htrans_in == HTRANS_SEQ);
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = hrdata_q;

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ahb_wr_q   <= 1'b0;
            ahb_addr_q <= 8'h00;
        end else begin
            ahb_wr_q   <= ahb_take && hwrite_in && (hsize_in == 3'b010);
            ahb_addr_q <= haddr_in[7:0];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            config_q <= `CFG_RESET;
        end else if (ahb_wr_q && ahb_addr_q == `REG_CONFIG) begin
            config_q <= hwdata_in[5:0];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            hrdata_q <= 32'h0000_0000;
        end else if (ahb_take && !hwrite_in) begin
            case (haddr_in[7:0])
                `REG_CONFIG: hrdata_q <= {26'h000_0000, config_q};
                `REG_STATUS: hrdata_q <= {20'h0_0000, tape_data_out[7:4], ctrl_q,
                                          dma_req_q, cmd_q == CMD_BUSY, read_mode_q,
                                          irq_q};
                default:     hrdata_q <= 32'h0000_0000;
            endcase
        end
    end

endmodule : tape_host_bus_if

// ---- tape_host_cfg.svh ----
// Constants for the tape adapter host-bus interface.
// Assumes inclusion by its bare name from the package and the design.
`ifndef TAPE_HOST_CFG_SVH
`define TAPE_HOST_CFG_SVH

// Base I/O addresses selected by the config register base field
`define BASE_ADDR_0       10'h108
`define BASE_ADDR_1       10'h118
`define BASE_ADDR_2       10'h208
`define BASE_ADDR_3       10'h218

// Port offsets within the base window
`define OFS_STATUS        2'h0
`define OFS_DRIVE         2'h1
`define OFS_ENGINE        2'h2
`define OFS_IRQ_ACK       2'h3

// Strobe positions in the one-hot port vector
`define PORT_RD_STATUS    0
`define PORT_RD_DRIVE     1
`define PORT_WR_COMMAND   2
`define PORT_RD_ENGINE    3
`define PORT_WR_CONTROL   4
`define PORT_IRQ_ACK      5

// Synchroniser vector layout
`define SY_ADDR_LO        0
`define SY_AEN            10
`define SY_IOR_N          11
`define SY_IOW_N          12
`define SY_TC             13
`define SY_BUS_RESET      14
`define SY_EXC_N          15
`define SY_ACK_N          16
`define SY_RDY_N          17
`define SY_DIR_N          18
`define SY_DACK_LO        19
`define SY_TD_LO          23
`define SYNC_IDLE         27'h07F_9C00

// Register offsets (byte addresses)
`define REG_CONFIG        8'h00
`define REG_STATUS        8'h04

// Config field positions
`define CFG_BASE_LO       0
`define CFG_IRQ_LO        2
`define CFG_DACK_LO       4
`define CFG_RESET         6'h00

// Control register bits
`define CTL_DRIVE_N_A        0
`define CTL_DRIVE_RESET   1
`define CTL_RESET         4'h0

`endif

// ---- tape_host_pkg.sv ----
// Types shared by the tape adapter host-bus interface.
// Assumes tape_host_cfg.svh is on the include path.
package tape_host_pkg;
    `include "tape_host_cfg.svh"

    typedef enum logic [1:0] {
        CMD_IDLE = 2'b00,
        CMD_BUSY = 2'b01,
        CMD_DONE = 2'b10
    } cmd_state_t;

    typedef enum logic [1:0] {
        HTRANS_IDLE   = 2'b00,
        HTRANS_BUSY   = 2'b01,
        HTRANS_NONSEQ = 2'b10,
        HTRANS_SEQ    = 2'b11
    } htrans_t;
endpackage : tape_host_pkg

// ---- tape_sva.sv ----
// Port checker for the tape adapter host-bus block.
// Assumes it is bound to tape_host_bus_if and sees only its ports.
`timescale 1ns/1ns
module tape_sva (
    input wire logic       mclk_in,
    input wire logic       rst_n_in,
    input wire logic       addr_enable_in,
    input wire logic       io_read_n_in,
    input wire logic       io_write_n_in,
    input wire logic       terminal_count_in,
    input wire logic       bus_reset_in,
    input wire logic       read_status_strobe_n_out,
    input wire logic       drive_status_read_strobe_n_out,
    input wire logic       command_request_write_strobe_n_out,
    input wire logic       read_engine_on_strobe_n_out,
    input wire logic       control_reg_write_strobe_n_out,
    input wire logic       irq_ack_strobe_n_out,
    input wire logic [7:0] tape_data_out,
    input wire logic       tape_data_oe_out,
    input wire logic       sys_data_dir_out,
    input wire logic [3:0] irq_out,
    input wire logic       operation_kill_out,
    input wire logic       drive_drive_n_a_n_out,
    input wire logic       drive_reset_n_out,
    input wire logic       master_reset_n_out,
    input wire logic       sys_data_enable_out,
    input wire logic       dma_request_out,
    input wire logic [3:0] dma_ack_n_in
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    wire [5:0] stb_n = {read_status_strobe_n_out, drive_status_read_strobe_n_out,
        command_request_write_strobe_n_out, read_engine_on_strobe_n_out,
        control_reg_write_strobe_n_out, irq_ack_strobe_n_out};
    one_strobe_a: assert property ($onehot0(~stb_n))
        else $error("two strobes low");
    aen_block_a: assert property (addr_enable_in [*4] |-> &stb_n)
        else $error("strobe during address enable");
    enable_gate_a: assert property (sys_data_enable_out |-> $past(!(&stb_n)))
        else $error("data buffers enabled without a strobe");
    ctl_write_a: assert property (
        !control_reg_write_strobe_n_out |-> $past(!io_write_n_in, 3))
        else $error("control strobe without write");
    stat_read_a: assert property (
        !read_status_strobe_n_out |-> $past(!io_read_n_in, 3))
        else $error("status strobe without read");
    dir_follow_a: assert property (!io_read_n_in [*5] |-> sys_data_dir_out)
        else $error("buffer direction not set");
    kill_pulse_a: assert property (
        $rose(terminal_count_in) |-> ##[1:5] operation_kill_out)
        else $error("no kill after terminal count");
    kill_once_a: assert property (operation_kill_out |=> !operation_kill_out)
        else $error("kill longer than a cycle");
    irq_line_a: assert property ($onehot0(irq_out))
        else $error("several interrupt lines");
    irq_hold_a: assert property ($fell(|irq_out) |-> $past(!irq_ack_strobe_n_out)
        || $past(!irq_ack_strobe_n_out, 2) || !master_reset_n_out)
        else $error("interrupt dropped early");
    status_oe_a: assert property (
        !drive_status_read_strobe_n_out [*2] |-> tape_data_oe_out)
        else $error("drive status not enabled");
    ctl_feed_a: assert property (tape_data_oe_out |->
        tape_data_out[1:0] == ~{drive_reset_n_out, drive_drive_n_a_n_out})
        else $error("control bits not fed back");
    dma_clear_a: assert property (!(&dma_ack_n_in) [*3] |=> !dma_request_out)
        else $error("request not cleared by acknowledge");
    bus_reset_a: assert property (bus_reset_in [*3] |-> !master_reset_n_out)
        else $error("bus reset not passed on");
endmodule : tape_sva

bind tape_host_bus_if tape_sva tape_sva_i (.*);

// ---- host_dma_model.sv ----
// Behavioural host DMA controller answering board data requests.
// Assumes dack_sel_in matches the board's configured acknowledge line.
`timescale 1ns/1ns
module host_dma_model (
    input  wire logic       mclk_in,
    input  wire logic       dma_request_in,
    input  wire logic [1:0] dack_sel_in,
    input  wire logic       slow_in,
    output logic      [3:0] dma_ack_n_out
);
    initial begin
        dma_ack_n_out <= 4'hF;
        forever begin
            @(posedge mclk_in);
            if (dma_request_in) begin
                repeat (slow_in ? 6 : 1) @(posedge mclk_in);
                if (dma_request_in) begin
                    dma_ack_n_out <= ~(4'h1 << dack_sel_in);
                    repeat (3) @(posedge mclk_in);
                    dma_ack_n_out <= 4'hF;
                end
                @(posedge mclk_in);
            end
        end
    end
endmodule : host_dma_model

// ---- tape_board_host_bus_interface_bench.sv ----
// Testbench: AHB registers, I/O port decoding, interrupts, DMA and kill.
// Assumes the design, tape_sva.sv and host_dma_model.sv are compiled first.
`timescale 1ns/1ns
`include "tape_host_cfg.svh"
module tape_board_host_bus_interface_bench import tape_host_pkg::*;;
    logic mclk_in, rst_n_in, addr_enable_in, io_read_n_in, io_write_n_in, slow;
    logic terminal_count_in, bus_reset_in, drive_exception_n_in, drive_ready_n_in;
    logic hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out, rd_ph = 0;
    logic read_status_strobe_n_out, drive_status_read_strobe_n_out, tape_data_oe_out;
    logic command_request_write_strobe_n_out, read_engine_on_strobe_n_out;
    logic control_reg_write_strobe_n_out, irq_ack_strobe_n_out, sys_data_dir_out;
    logic sys_data_enable_out, operation_kill_out, read_mode_out, request_n_out;
    logic dma_request_out, drive_drive_n_a_n_out, drive_reset_n_out, master_reset_n_out;
    logic drive_ack_n_in, drive_dir_n_in;
    logic [1:0] htrans_in;
    logic [2:0] hsize_in;
    logic [3:0] dma_ack_n_in, tape_data_in, irq_out, td;
    logic [7:0] tape_data_out;
    logic [9:0] sys_addr_in, base;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, cfg, eq[$], mq[$], pq[$];
    logic [9:0] bases[4] = '{`BASE_ADDR_0, `BASE_ADDR_1, `BASE_ADDR_2, `BASE_ADDR_3};
    int error_cnt = 0, n_checks = 0, seed = 24900, n_dreq = 0;
    event pin_ev;
    wire [31:0] pvec = {20'h0, hresp_out, sys_data_enable_out, request_n_out, irq_out,
        read_mode_out, dma_request_out, drive_drive_n_a_n_out, drive_reset_n_out,
        master_reset_n_out};
    assign hready_in = hreadyout_out;
    tape_host_bus_if tape_host_bus_if_i (.*);
    host_dma_model host_dma_model_i (.mclk_in, .dma_request_in(dma_request_out),
        .dack_sel_in(cfg[5:4]), .slow_in(slow), .dma_ack_n_out(dma_ack_n_in));
    initial begin
        mclk_in = 0;
        forever #20 mclk_in = ~mclk_in;
    end
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    always @(posedge mclk_in) begin
        if (rd_ph && hreadyout_out === 1'h1) chk("hrdata", hrdata_out & mq.pop_front(),
            eq.pop_front());
        if (hreadyout_out === 1'h1) rd_ph <= htrans_in == HTRANS_NONSEQ && !hwrite_in;
    end
    always @(pin_ev) chk("pins", pvec, pq.pop_front());
    always @(posedge dma_request_out) n_dreq++;
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : cyc
    task automatic wrdy();
        int n;
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (hreadyout_out !== 1'h1 && n < 20);
        if (hreadyout_out !== 1'h1) begin
            error_cnt++;
            stop_test();
        end
    endtask : wrdy
    task automatic ahb(input logic w, input logic [31:0] a, d, m);
        if (!w) begin
            eq.push_back(d & m);
            mq.push_back(m);
        end
        htrans_in <= HTRANS_NONSEQ;
        haddr_in <= a;
        hwrite_in <= w;
        wrdy();
        htrans_in <= HTRANS_IDLE;
        hwdata_in <= d;
        wrdy();
    endtask : ahb
    task automatic io(input logic [9:0] a, input logic wr);
        sys_addr_in <= a;
        io_write_n_in <= !wr;
        io_read_n_in <= wr;
        cyc(5);
        io_write_n_in <= 1'h1;
        io_read_n_in <= 1'h1;
        cyc(6);
    endtask : io
    task automatic low(input logic exc, input int n);
        if (exc) drive_exception_n_in <= 1'h0;
        else drive_ready_n_in <= 1'h0;
        cyc(n);
        drive_exception_n_in <= 1'h1;
        drive_ready_n_in <= 1'h1;
        cyc(n);
    endtask : low
    task automatic pins(input logic [3:0] q, input logic [1:0] m, input logic r);
        @(negedge mclk_in);
        pq.push_back({20'h0, 2'h0, r, q, m, ~td[0], ~td[1], 1'h1});
        -> pin_ev;
        cyc(1);
    endtask : pins
    initial begin
        {rst_n_in, addr_enable_in, terminal_count_in, bus_reset_in, slow} = '0;
        {io_read_n_in, io_write_n_in, drive_exception_n_in, drive_ready_n_in} = 4'hF;
        {drive_ack_n_in, drive_dir_n_in, hsel_in, hwrite_in} = 4'hE;
        {htrans_in, hsize_in, haddr_in, hwdata_in, cfg, td} = {2'h0, 3'h2, 100'h0};
        {sys_addr_in, tape_data_in} = '0;
        cyc(12);
        rst_n_in <= 1'h1;
        ahb(0, 32'h10, 0, 32'hFFFF_FFFF);
        for (int k = 0; k < 4; k++) begin
            cfg = {26'h0, 2'($random(seed)), 2'(3 - k), 2'(k)};
            base = bases[k];
            slow = k[0];
            ahb(1, `REG_CONFIG, cfg, 0);
            ahb(0, `REG_CONFIG, cfg, 32'h3F);
            td = 4'($random(seed));
            tape_data_in <= td;
            io(base + 10'h1, 1);
            tape_data_in <= ~td;
            io(base + 10'h5, 1);
            addr_enable_in <= 1'h1;
            io(base + 10'h1, 1);
            addr_enable_in <= 1'h0;
            pins(4'h0, 2'h0, 1'h1);
            io(base + 10'h1, 0);
            ahb(0, `REG_STATUS, {20'h0, 4'hF, td, 4'h0}, 32'hFF0);
            io(base, 1);
            ahb(0, `REG_STATUS, 32'h4, 32'h7);
            pins(4'h0, 2'h0, 1'h0);
            low(1'h0, 4);
            pins(4'h1 << cfg[3:2], 2'h0, 1'h1);
            io(base, 0);
            ahb(0, `REG_STATUS, 32'h1, 32'h7);
            io(base + 10'h3, 1);
            pins(4'h0, 2'h0, 1'h1);
            low(1'h1, 6);
            pins(4'h1 << cfg[3:2], 2'h0, 1'h1);
            io(base + 10'h3, 1);
            io(base + 10'h2, 0);
            low(1'h0, 20);
            pins(4'h0, 2'h2, 1'h1);
            terminal_count_in <= 1'h1;
            cyc(4);
            terminal_count_in <= 1'h0;
            cyc(4);
            pins(4'h0, 2'h0, 1'h1);
        end
        chk("dma requests", 32'(n_dreq >= 4), 32'h1);
        bus_reset_in <= 1'h1;
        cyc(4);
        td = 4'h0;
        @(negedge mclk_in);
        pq.push_back(32'h206);
        -> pin_ev;
        cyc(1);
        bus_reset_in <= 1'h0;
        cyc(4);
        ahb(0, `REG_CONFIG, cfg, 32'h3F);
        stop_test();
    end
endmodule : tape_board_host_bus_interface_bench
